// file: dhi_defines.svh
// Constants of the display host port
// Functional notes
// - While the reset pin is low the controller logic stays in initialisation.
// - Data/command select high: the transferred byte is display data.
// - Data/command select low: the transferred byte goes to the command register.
// - Two-wire mode uses the data/command pin as slave address bit zero.
// - 68-style: read/write select high reads, low writes.
// - 80-style: write begins with write strobe and chip select both low.
// - 68-style: transfer begins when enable rises with chip select low.
// - 80-style: read strobe and chip select low start a read, bus driven.
// - Parallel data bus is 8-bit, two-way, driven by us only in reads and, on line 2, for the two-wire acknowledge.
// - Serial mode takes its input data from data line 1.
// - Serial mode takes the host serial clock wired from data line 0.
// - Two-wire mode takes its bus clock on data line 0.
`ifndef DHI_DEFINES_SVH
`define DHI_DEFINES_SVH

`define DHI_DW 8
`define DHI_FIFO_DEPTH 32
`define DHI_NPIN 16
`define DHI_P_SCL 0
`define DHI_P_SDA_IN 1
`define DHI_P_CSN 8
`define DHI_P_DC 9
`define DHI_P_RW 10
`define DHI_P_ER 11
`define DHI_P_RSTN 12
`define DHI_PIN_IDLE 16'h1100
`define DHI_STRAP_I2C 3'h2
`define DHI_STRAP_SPI3 3'h4
`define DHI_STRAP_SPI4 3'h0
`define DHI_STRAP_P68 3'h1
`define DHI_STRAP_P80 3'h3
`define DHI_LOCK_CYC 3'h5
`define DHI_I2C_ADDR_HI 6'h15
`define DHI_CTRL_DC_BIT 6
`define DHI_OE_ALL 8'hFF
`define DHI_OE_ACK 8'h04
`define DHI_OE_NONE 8'h00

`endif

// file: dhi_fifo.sv
// Parameterised synchronous FIFO with valid/ready on both sides
`timescale 1ns/1ns
module dhi_fifo #(
    parameter int W = 9,
    parameter int DEPTH = 32
) (
    // System
    input wire logic clk,
    input wire logic rst,
    // Streams
    dhi_stream_if.snk wr,
    dhi_stream_if.src rd
);
    localparam int AW = $clog2(DEPTH);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [AW:0] wp;
        logic [AW:0] rp;
    } dhi_fifo_state_t;

    dhi_fifo_state_t st;
    dhi_fifo_state_t next_st;
    logic full;
    logic empty;

    // Extra pointer bit tells full from empty
    assign empty = (st.wp == st.rp);
    assign full = (st.wp[AW] != st.rp[AW]) &&
                  (st.wp[AW-1:0] == st.rp[AW-1:0]);
    assign wr.ready = ~full;
    assign rd.valid = ~empty;
    assign rd.data = st.mem[st.rp[AW-1:0]];

    always_comb begin
        next_st = st;
        if (wr.valid && !full) begin
            next_st.mem[st.wp[AW-1:0]] = wr.data;
            next_st.wp = st.wp + 1'b1;
        end
        if (!empty && rd.ready) begin
            next_st.rp = st.rp + 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end
endmodule : dhi_fifo

// file: dhi_host_model.sv
// Host processor model driving the display host pins
`timescale 1ns/1ns
module dhi_host_model (
    // Timing reference
    input wire logic clk,
    // Pins toward the device
    output logic serial_clock,
    output logic chip_select_low,
    output logic data_command_select,
    output logic read_write_select,
    output logic enable_read_strobe,
    output logic [7:0] host_data_bus_in,
    // Device drive of the data bus
    input wire logic [7:0] host_data_bus_out,
    input wire logic [7:0] host_data_bus_oe
);
    logic [7:0] drv = 8'h00;
    logic drv_en = 1'b0;
    logic two_wire = 1'b0;
    logic scl = 1'b1;
    logic sda = 1'b1;
    logic sda_line;
    initial begin
        serial_clock = 1'b0;
        chip_select_low = 1'b1;
        data_command_select = 1'b0;
        read_write_select = 1'b1;
        enable_read_strobe = 1'b1;
    end
    // Pulled up; the device can only pull line 2 low
    assign sda_line = sda & ~(host_data_bus_oe[2] & ~host_data_bus_out[2]);
    // Released lines show the inverse of the last host value
    always_comb begin
        host_data_bus_in = (host_data_bus_oe & host_data_bus_out)
            | (~host_data_bus_oe & (drv_en ? drv : ~drv));
        if (two_wire) begin
            host_data_bus_in[2:0] = {sda_line, sda_line, scl};
        end
    end
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    // Select and data settle one cycle ahead of the strobe
    task automatic par_start(input logic m68, input logic rd,
            input logic dc, input logic [7:0] d, input logic cs_n);
        chip_select_low = cs_n;
        data_command_select = dc;
        drv = d;
        drv_en = !rd;
        read_write_select = m68 ? rd : 1'b1;
        enable_read_strobe = !m68;
        cyc(1);
        read_write_select = rd;
        enable_read_strobe = m68 | !rd;
        cyc(6);
    endtask : par_start
    // Direction held past the strobe so it is never misread
    task automatic par_stop(input logic m68);
        if (!m68) begin
            read_write_select = 1'b1;
        end
        enable_read_strobe = !m68;
        cyc(1);
        chip_select_low = 1'b1;
        drv_en = 1'b0;
    endtask : par_stop
    // Serial clock idles low and runs only inside a frame
    task automatic spi_byte(input logic three, input logic dc,
            input logic [7:0] d);
        logic [8:0] bits;
        bits = three ? {dc, d} : {d, 1'b0};
        chip_select_low = 1'b0;
        data_command_select = dc;
        drv_en = 1'b1;
        for (int i = 8; i >= (three ? 0 : 1); i--) begin
            drv[1] = bits[i];
            #3 serial_clock = 1'b1;
            #3 serial_clock = 1'b0;
        end
        cyc(1);
        chip_select_low = 1'b1;
        drv_en = 1'b0;
        cyc(12);
    endtask : spi_byte
    // Start, n bytes from the top of b, each acked, then stop
    task automatic i2c_xfer(input logic [23:0] b, input int n,
            output logic acked);
        acked = 1'b1;
        sda = 1'b0;
        cyc(6);
        scl = 1'b0;
        for (int k = 0; k < n; k++) begin
            for (int i = 7; i >= 0; i--) begin
                sda = b[16 - 8 * k + i];
                cyc(6);
                scl = 1'b1;
                cyc(6);
                scl = 1'b0;
            end
            sda = 1'b1;
            cyc(6);
            scl = 1'b1;
            acked = acked & !sda_line;
            cyc(6);
            scl = 1'b0;
        end
        cyc(6);
        sda = 1'b0;
        cyc(6);
        scl = 1'b1;
        cyc(6);
        sda = 1'b1;
        cyc(6);
    endtask : i2c_xfer
endmodule : dhi_host_model

// file: dhi_host_port.sv
// Host pin interface: parallel 68/80, serial and two-wire decoding
`timescale 1ns/1ns
`include "dhi_defines.svh"
module dhi_host_port #(
    parameter int DEPTH = `DHI_FIFO_DEPTH
) (
    // System
    input wire logic clk,
    input wire logic sys_rst,
    // Host link clock, board-wired from data line 0
    input wire logic serial_clock,
    // Host control pins
    input wire logic controller_reset_low,
    input wire logic chip_select_low,
    input wire logic data_command_select,
    input wire logic read_write_select,
    input wire logic enable_read_strobe,
    // Host data bus, split
    input wire logic [7:0] host_data_bus_in,
    output logic [7:0] host_data_bus_out,
    output logic [7:0] host_data_bus_oe,
    // Interface select straps
    input wire logic interface_select_strap_a,
    input wire logic interface_select_strap_b,
    input wire logic interface_select_strap_c,
    // Controller read side
    input wire logic [7:0] read_data,
    output logic read_ack,
    // Controller write stream
    output logic out_valid,
    input wire logic out_ready,
    output logic [7:0] out_data,
    output logic out_is_data,
    // Status
    output logic write_busy,
    output logic overflow,
    input wire logic overflow_clear,
    output logic controller_init,
    output logic [5:0] interface_mode
);
    dhi_pkg::dhi_state_t st;
    dhi_pkg::dhi_state_t next_st;
    dhi_pkg::dhi_link_t lk;
    dhi_pkg::dhi_link_t next_lk;
    logic [3:0] lcnt;
    logic [3:0] next_lcnt;
    logic [2:0] straps;
    logic fifo_rst;

    dhi_stream_if #(.W(9)) fin ();
    dhi_stream_if #(.W(9)) fout ();

    function automatic dhi_pkg::dhi_mode_t mode_of(input logic [2:0] s);
        case (s)
            `DHI_STRAP_I2C: mode_of = dhi_pkg::dhi_m_i2c;
            `DHI_STRAP_SPI3: mode_of = dhi_pkg::dhi_m_spi3;
            `DHI_STRAP_SPI4: mode_of = dhi_pkg::dhi_m_spi4;
            `DHI_STRAP_P68: mode_of = dhi_pkg::dhi_m_p68;
            `DHI_STRAP_P80: mode_of = dhi_pkg::dhi_m_p80;
            default: mode_of = dhi_pkg::dhi_m_none;
        endcase
    endfunction : mode_of

    assign straps = {interface_select_strap_a, interface_select_strap_b,
                     interface_select_strap_c};

    // Link domain: straps are static board ties, read directly here
    always_comb begin
        logic sp3;
        logic last;
        sp3 = (straps == `DHI_STRAP_SPI3);
        last = sp3 ? (lcnt == 4'h8) : (lcnt == 4'h7);
        next_lk = lk;
        next_lcnt = lcnt + 4'h1;
        if (sp3 && lcnt == 4'h0) begin
            next_lk.dc = host_data_bus_in[`DHI_P_SDA_IN];
        end else begin
            next_lk.shift = {lk.shift[6:0],
                             host_data_bus_in[`DHI_P_SDA_IN]};
        end
        if (last) begin
            next_lk.hold = {sp3 ? lk.dc : data_command_select,
                            lk.shift[6:0], host_data_bus_in[`DHI_P_SDA_IN]};
            next_lk.tog = ~lk.tog;
            next_lcnt = 4'h0;
        end
    end

    // Clock stops between frames, so hold and toggle need no frame end
    always_ff @(posedge serial_clock or posedge sys_rst) begin
        if (sys_rst) begin
            lk <= '0;
        end else begin
            lk <= next_lk;
        end
    end

    // Deselect realigns the bit count without any link edge
    always_ff @(posedge serial_clock or posedge chip_select_low) begin
        if (chip_select_low) begin
            lcnt <= 4'h0;
        end else begin
            lcnt <= next_lcnt;
        end
    end

    assign fifo_rst = sys_rst | st.init;
    assign fin.valid = st.pv;
    assign fin.data = st.pd;
    assign fout.ready = ~st.ov | out_ready;

    dhi_fifo #(.W(9), .DEPTH(DEPTH)) u_fifo (
        .clk(clk),
        .rst(fifo_rst),
        .wr(fin),
        .rd(fout)
    );

    always_comb begin
        logic [`DHI_NPIN-1:0] pin;
        logic csl;
        logic p80;
        logic p68;
        logic wa;
        logic ra;
        logic scl;
        logic sda;
        pin = {straps, controller_reset_low, enable_read_strobe,
               read_write_select, data_command_select, chip_select_low,
               host_data_bus_in};
        next_st = st;
        next_st.s1 = pin;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
        // A bit changes once stages two and three agree
        next_st.f = (st.s3 & ~(st.s2 ^ st.s3)) | (st.f & (st.s2 ^ st.s3));
        next_st.pv = 1'b0;
        next_st.rd_ack = 1'b0;
        next_st.init = ~st.f[`DHI_P_RSTN];
        if (st.lock != `DHI_LOCK_CYC) begin
            next_st.lock = st.lock + 3'h1;
            next_st.mode = mode_of(st.f[15:13]);
        end

        // Parallel strobes count only under chip select
        csl = ~st.f[`DHI_P_CSN];
        p80 = (st.mode == dhi_pkg::dhi_m_p80);
        p68 = (st.mode == dhi_pkg::dhi_m_p68);
        wa = csl & ((p80 & ~st.f[`DHI_P_RW]) |
             (p68 & st.f[`DHI_P_ER] & ~st.f[`DHI_P_RW]));
        ra = csl & ((p80 & ~st.f[`DHI_P_ER]) |
             (p68 & st.f[`DHI_P_ER] & st.f[`DHI_P_RW]));
        next_st.wact = wa;
        next_st.ract = ra;
        if (wa) begin
            next_st.wbyte = st.f[7:0];
            next_st.wdc = st.f[`DHI_P_DC];
        end
        // Byte taken at strobe end, when host data is surely settled
        if (st.wact && !wa) begin
            next_st.pv = 1'b1;
            next_st.pd = {st.wdc, st.wbyte};
        end
        if (st.ract && !ra) begin
            next_st.rd_ack = 1'b1;
        end

        // Serial bytes cross by toggle; hold is stable long before use
        next_st.tg1 = lk.tog;
        next_st.tg2 = st.tg1;
        next_st.tg3 = st.tg2;
        if (st.tg2 == st.tg3 && st.tg3 != st.tg_seen) begin
            next_st.tg_seen = st.tg3;
            if (st.mode == dhi_pkg::dhi_m_spi3 ||
                st.mode == dhi_pkg::dhi_m_spi4) begin
                next_st.pv = 1'b1;
                next_st.pd = lk.hold;
            end
        end

        // Two-wire receiver, oversampled in the system domain
        scl = st.f[`DHI_P_SCL];
        sda = st.f[`DHI_P_SDA_IN];
        next_st.sclp = scl;
        next_st.sdap = sda;
        if (st.mode != dhi_pkg::dhi_m_i2c ||
            (scl && st.sclp && !st.sdap && sda)) begin
            next_st.ist = dhi_pkg::dhi_i_idle;
            next_st.iack = 1'b0;
        end else if (scl && st.sclp && st.sdap && !sda) begin
            next_st.ist = dhi_pkg::dhi_i_addr;
            next_st.icnt = 4'h0;
            next_st.iack = 1'b0;
        end else if (st.ist != dhi_pkg::dhi_i_idle) begin
            if (scl && !st.sclp && st.icnt < 4'h8) begin
                next_st.ishift = {st.ishift[6:0], sda};
                next_st.icnt = st.icnt + 4'h1;
            end else if (!scl && st.sclp && st.icnt == 4'h8) begin
                next_st.icnt = 4'h9;
                case (st.ist)
                    dhi_pkg::dhi_i_addr: begin
                        if (st.ishift == {`DHI_I2C_ADDR_HI,
                            st.f[`DHI_P_DC], 1'b0}) begin
                            next_st.iack = 1'b1;
                            next_st.ist = dhi_pkg::dhi_i_ctrl;
                        end else begin
                            next_st.ist = dhi_pkg::dhi_i_idle;
                        end
                    end
                    dhi_pkg::dhi_i_ctrl: begin
                        next_st.idc = st.ishift[`DHI_CTRL_DC_BIT];
                        next_st.iack = 1'b1;
                        next_st.ist = dhi_pkg::dhi_i_data;
                    end
                    dhi_pkg::dhi_i_data: begin
                        next_st.pv = 1'b1;
                        next_st.pd = {st.idc, st.ishift};
                        next_st.iack = ~st.busy;
                    end
                    default: begin
                        next_st.ist = dhi_pkg::dhi_i_idle;
                    end
                endcase
            end else if (!scl && st.sclp && st.icnt == 4'h9) begin
                next_st.iack = 1'b0;
                next_st.icnt = 4'h0;
            end
        end

        // Only reads and the two-wire acknowledge drive the bus
        if (ra) begin
            next_st.oe = `DHI_OE_ALL;
            next_st.dout = read_data;
        end else if (next_st.iack) begin
            next_st.oe = `DHI_OE_ACK;
            next_st.dout = 8'h00;
        end else begin
            next_st.oe = `DHI_OE_NONE;
            next_st.dout = 8'h00;
        end

        // Parallel host cannot be stalled: a full FIFO drops and flags
        next_st.busy = ~fin.ready;
        if (overflow_clear) begin
            next_st.ovf = 1'b0;
        end
        if (st.pv && !fin.ready) begin
            next_st.ovf = 1'b1;
        end
        if (!st.ov || out_ready) begin
            next_st.ov = fout.valid;
            next_st.od = fout.data;
        end

        if (!st.f[`DHI_P_RSTN]) begin
            next_st.mode = mode_of(st.f[15:13]);
            next_st.wact = 1'b0;
            next_st.ract = 1'b0;
            next_st.rd_ack = 1'b0;
            next_st.ist = dhi_pkg::dhi_i_idle;
            next_st.icnt = 4'h0;
            next_st.iack = 1'b0;
            next_st.pv = 1'b0;
            next_st.ov = 1'b0;
            next_st.ovf = 1'b0;
            next_st.oe = `DHI_OE_NONE;
            next_st.dout = 8'h00;
            next_st.tg_seen = st.tg3;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            st <= '0;
            st.s1 <= `DHI_PIN_IDLE;
            st.s2 <= `DHI_PIN_IDLE;
            st.s3 <= `DHI_PIN_IDLE;
            st.f <= `DHI_PIN_IDLE;
            st.mode <= dhi_pkg::dhi_m_none;
            st.ist <= dhi_pkg::dhi_i_idle;
        end else begin
            st <= next_st;
        end
    end

    assign host_data_bus_out = st.dout;
    assign host_data_bus_oe = st.oe;
    assign read_ack = st.rd_ack;
    assign out_valid = st.ov;
    assign out_data = st.od[7:0];
    assign out_is_data = st.od[8];
    assign write_busy = st.busy;
    assign overflow = st.ovf;
    assign controller_init = st.init;
    assign interface_mode = st.mode;

    property p_init;
        @(posedge clk) disable iff (sys_rst)
        !st.f[`DHI_P_RSTN] |=> st.init && st.oe == `DHI_OE_NONE;
    endproperty
    a_init: assert property (p_init)
        else $error("reset pin low did not hold init");

    property p_i2c_dc;
        @(posedge clk) disable iff (sys_rst)
        (st.pv && st.mode == dhi_pkg::dhi_m_i2c) |-> st.pd[8] == st.idc;
    endproperty
    a_i2c_dc: assert property (p_i2c_dc)
        else $error("two-wire byte lost its data/command flag");

    property p_par_push;
        @(posedge clk) disable iff (sys_rst)
        $fell(st.wact) && st.f[`DHI_P_RSTN] |->
        st.pv && st.pd == {st.wdc, st.wbyte};
    endproperty
    a_par_push: assert property (p_par_push)
        else $error("parallel write not pushed at strobe end");

    property p_addr_lsb;
        @(posedge clk) disable iff (sys_rst)
        ($past(st.ist) == dhi_pkg::dhi_i_addr &&
         st.ist == dhi_pkg::dhi_i_ctrl) |->
        $past(st.ishift[1]) == $past(st.f[`DHI_P_DC]);
    endproperty
    a_addr_lsb: assert property (p_addr_lsb)
        else $error("address accepted with wrong low bit");

    property p_rd_ack;
        @(posedge clk) disable iff (sys_rst)
        $fell(st.ract) && st.f[`DHI_P_RSTN] |-> st.rd_ack ##1 !st.rd_ack;
    endproperty
    a_rd_ack: assert property (p_rd_ack)
        else $error("read end not acknowledged for one cycle");

    property p_drive_read;
        @(posedge clk) disable iff (sys_rst)
        st.oe[7] |-> st.ract && st.oe == `DHI_OE_ALL;
    endproperty
    a_drive_read: assert property (p_drive_read)
        else $error("data bus driven outside a read");

    property p_spi_word;
        @(posedge clk) disable iff (sys_rst)
        (st.pv && st.mode == dhi_pkg::dhi_m_spi4) |-> st.pd == lk.hold;
    endproperty
    a_spi_word: assert property (p_spi_word)
        else $error("serial byte corrupted in crossing");

    property p_mode;
        @(posedge clk) disable iff (sys_rst)
        $onehot(st.mode) && (st.mode == dhi_pkg::dhi_m_i2c ||
        st.ist == dhi_pkg::dhi_i_idle || $past(st.mode) != st.mode);
    endproperty
    a_mode: assert property (p_mode)
        else $error("mode not single or two-wire active off mode");

    property p_cs_idle;
        @(posedge clk) disable iff (sys_rst)
        (st.f[`DHI_P_CSN] && st.f[`DHI_P_RSTN]) |=> !st.wact && !st.ract;
    endproperty
    a_cs_idle: assert property (p_cs_idle)
        else $error("strobe acted without chip select");
endmodule : dhi_host_port

// file: dhi_pkg.sv
// Types of the display host port
`include "dhi_defines.svh"
package dhi_pkg;

    typedef enum logic [5:0] {
        dhi_m_none = 6'h01,
        dhi_m_i2c = 6'h02,
        dhi_m_spi3 = 6'h04,
        dhi_m_spi4 = 6'h08,
        dhi_m_p68 = 6'h10,
        dhi_m_p80 = 6'h20
    } dhi_mode_t;

    typedef enum logic [3:0] {
        dhi_i_idle = 4'h1,
        dhi_i_addr = 4'h2,
        dhi_i_ctrl = 4'h4,
        dhi_i_data = 4'h8
    } dhi_i2c_t;

    typedef struct packed {
        logic [`DHI_NPIN-1:0] s1;
        logic [`DHI_NPIN-1:0] s2;
        logic [`DHI_NPIN-1:0] s3;
        logic [`DHI_NPIN-1:0] f;
        dhi_mode_t mode;
        logic [2:0] lock;
        logic init;
        logic wact;
        logic ract;
        logic [`DHI_DW-1:0] wbyte;
        logic wdc;
        logic [`DHI_DW-1:0] dout;
        logic [`DHI_DW-1:0] oe;
        logic rd_ack;
        logic tg1;
        logic tg2;
        logic tg3;
        logic tg_seen;
        dhi_i2c_t ist;
        logic [3:0] icnt;
        logic [`DHI_DW-1:0] ishift;
        logic idc;
        logic iack;
        logic sclp;
        logic sdap;
        logic pv;
        logic [`DHI_DW:0] pd;
        logic ov;
        logic [`DHI_DW:0] od;
        logic busy;
        logic ovf;
    } dhi_state_t;

    typedef struct packed {
        logic [`DHI_DW-1:0] shift;
        logic dc;
        logic [`DHI_DW:0] hold;
        logic tog;
    } dhi_link_t;

endpackage : dhi_pkg

// file: dhi_stream_if.sv
// Valid/ready byte stream between the port and its FIFO
`timescale 1ns/1ns
interface dhi_stream_if #(parameter int W = 9);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport snk (input valid, input data, output ready);
endinterface : dhi_stream_if

// file: display_host_interface_pins_test.sv
// Self-checking bench for the display host port
`timescale 1ns/1ns
`define CHK(got, exp) begin compares++; if ((got) !== (exp)) begin \
    mismatches++; \
    $display("MISMATCH %0t got %h exp %h", $time, got, exp); end end
module display_host_interface_pins_test;
    logic clk;
    logic sys_rst;
    logic controller_reset_low;
    logic [2:0] straps;
    logic [7:0] read_data;
    logic out_ready;
    logic overflow_clear;
    logic serial_clock, chip_select_low, data_command_select;
    logic read_write_select, enable_read_strobe, read_ack;
    logic [7:0] host_data_bus_in, host_data_bus_out, host_data_bus_oe;
    logic out_valid, out_is_data, write_busy, overflow, controller_init;
    logic [7:0] out_data;
    logic [5:0] interface_mode;
    logic ack;
    int mismatches = 0;
    int compares = 0;
    int acks;
    always #25 clk = ~clk;
    dhi_host_port #(.DEPTH(32)) uut (
        .clk(clk), .sys_rst(sys_rst), .serial_clock(serial_clock),
        .controller_reset_low(controller_reset_low),
        .chip_select_low(chip_select_low),
        .data_command_select(data_command_select),
        .read_write_select(read_write_select),
        .enable_read_strobe(enable_read_strobe),
        .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe),
        .interface_select_strap_a(straps[2]),
        .interface_select_strap_b(straps[1]),
        .interface_select_strap_c(straps[0]),
        .read_data(read_data), .read_ack(read_ack),
        .out_valid(out_valid), .out_ready(out_ready),
        .out_data(out_data), .out_is_data(out_is_data),
        .write_busy(write_busy), .overflow(overflow),
        .overflow_clear(overflow_clear),
        .controller_init(controller_init),
        .interface_mode(interface_mode));
    dhi_host_model host (
        .clk(clk), .serial_clock(serial_clock),
        .chip_select_low(chip_select_low),
        .data_command_select(data_command_select),
        .read_write_select(read_write_select),
        .enable_read_strobe(enable_read_strobe),
        .host_data_bus_in(host_data_bus_in),
        .host_data_bus_out(host_data_bus_out),
        .host_data_bus_oe(host_data_bus_oe));
    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #2;
    endtask : cyc
    task automatic idle_count(input int n);
        acks = 0;
        repeat (n) begin
            @(posedge clk);
            #1;
            if (read_ack === 1'b1) begin
                acks++;
            end
        end
        #1;
    endtask : idle_count
    // Consumer stalls until a byte stands, then takes it
    task automatic pop(input logic [7:0] d, input logic dc);
        for (int k = 0; k < 40 && out_valid !== 1'b1; k++) begin
            cyc(1);
        end
        `CHK(out_valid, 1'b1);
        `CHK(out_data, d);
        `CHK(out_is_data, dc);
        out_ready = 1'b1;
        cyc(1);
        out_ready = 1'b0;
        cyc(1);
    endtask : pop
    // Straps are only taken on reset, so each change needs one
    task automatic set_mode(input logic [2:0] s, input logic [5:0] m);
        straps = s;
        sys_rst = 1'b1;
        cyc(2);
        sys_rst = 1'b0;
        cyc(10);
        `CHK(interface_mode, m);
    endtask : set_mode
    task automatic t_modes();
        logic [2:0] codes [5];
        codes = '{3'h2, 3'h4, 3'h0, 3'h1, 3'h3};
        for (int i = 0; i < 5; i++) begin
            set_mode(codes[i], 6'h02 << i);
        end
    endtask : t_modes
    task automatic t_init();
        controller_reset_low = 1'b0;
        cyc(8);
        `CHK(controller_init, 1'b1);
        `CHK(out_valid, 1'b0);
        controller_reset_low = 1'b1;
        cyc(10);
        `CHK(controller_init, 1'b0);
    endtask : t_init
    task automatic t_p80();
        host.par_start(0, 0, 1, 8'hA5, 0);
        host.par_stop(0);
        pop(8'hA5, 1'b1);
        host.par_start(0, 0, 0, 8'h3C, 0);
        host.par_stop(0);
        pop(8'h3C, 1'b0);
        host.par_start(0, 0, 1, 8'h11, 1);
        host.par_stop(0);
        idle_count(12);
        `CHK(out_valid, 1'b0);
        read_data = 8'h96;
        host.par_start(0, 1, 1, 8'h00, 0);
        `CHK(host_data_bus_oe, 8'hFF);
        `CHK(host_data_bus_in, 8'h96);
        host.par_stop(0);
        idle_count(8);
        `CHK(acks, 1);
        `CHK(host_data_bus_oe, 8'h00);
        host.par_start(0, 1, 1, 8'h00, 1);
        `CHK(host_data_bus_oe, 8'h00);
        host.par_stop(0);
        idle_count(8);
        `CHK(acks, 0);
    endtask : t_p80
    task automatic t_p68();
        set_mode(3'h1, 6'h10);
        host.par_start(1, 0, 1, 8'h5A, 0);
        host.par_stop(1);
        pop(8'h5A, 1'b1);
        read_data = 8'h69;
        host.par_start(1, 1, 0, 8'h00, 0);
        `CHK(host_data_bus_oe, 8'hFF);
        `CHK(host_data_bus_in, 8'h69);
        host.par_stop(1);
        idle_count(8);
        `CHK(acks, 1);
    endtask : t_p68
    // Output register holds one byte beyond the 32 in the FIFO
    task automatic t_fifo();
        set_mode(3'h3, 6'h20);
        for (int i = 0; i < 34; i++) begin
            host.par_start(0, 0, 1, 8'(i), 0);
            host.par_stop(0);
            cyc(4);
        end
        // Last drop lands six cycles after the strobe pin rises
        cyc(2);
        `CHK(write_busy, 1'b1);
        `CHK(overflow, 1'b1);
        overflow_clear = 1'b1;
        cyc(1);
        overflow_clear = 1'b0;
        cyc(1);
        `CHK(overflow, 1'b0);
        for (int i = 0; i < 33; i++) begin
            pop(8'(i), 1'b1);
        end
        cyc(4);
        `CHK(out_valid, 1'b0);
        `CHK(write_busy, 1'b0);
    endtask : t_fifo
    task automatic t_serial();
        set_mode(3'h0, 6'h08);
        host.spi_byte(0, 1, 8'hC3);
        pop(8'hC3, 1'b1);
        host.spi_byte(0, 0, 8'h81);
        pop(8'h81, 1'b0);
        set_mode(3'h4, 6'h04);
        host.spi_byte(1, 1, 8'h7E);
        pop(8'h7E, 1'b1);
        host.two_wire = 1'b1;
        host.data_command_select = 1'b1;
        set_mode(3'h2, 6'h02);
        // Address, control byte with data flag set, one data byte
        host.i2c_xfer(24'h5640A7, 3, ack);
        `CHK(ack, 1'b1);
        pop(8'hA7, 1'b1);
        host.i2c_xfer(24'h540000, 1, ack);
        `CHK(ack, 1'b0);
    endtask : t_serial
    task automatic stop_test();
        $display("Compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask : stop_test
    initial begin
        clk = 1'b0;
        sys_rst = 1'b1;
        controller_reset_low = 1'b1;
        straps = 3'h3;
        read_data = 8'h00;
        out_ready = 1'b0;
        overflow_clear = 1'b0;
        cyc(16);
        sys_rst = 1'b0;
        cyc(10);
        t_modes();
        t_init();
        t_p80();
        t_p68();
        t_fifo();
        t_serial();
        stop_test();
    end
    initial begin
        #2000000;
        mismatches++;
        stop_test();
    end
endmodule : display_host_interface_pins_test
